// file: ocdc_ctrl.sv
// Purpose: debug flow control, comparators, trace and link access.
// Assumes: CPU gives one traced event per cycle at most.
// Notes: link pins are sampled; the link clock is not a domain.
//
// Functional notes
// - six comparators watch instruction fetch PC
// - two comparators watch CPU data accesses
// - any comparator may act as watchpoint
// - instruction comparator pairs combine into address range
// - halt command, breakpoint instruction, hardware match
// - compare address, optionally data value, report match
// - breakpoint enters debug, halting CPU outside monitor mode; watchpoint only reported
// - watchpoint starts or stops all trace
// - indexed registers read/written by link messages
// - CPU reaches registers through register port
// - trace and watch messages pass transmit queue
// - external mode feeds instruction register, halts empty
// - monitor mode ignores debug instruction register
// - single step: one fetch, then debug again
// - program trace only on changes of flow
// - ordered messages, addresses relative to previous
// - periodic sync messages carry absolute addresses
// - data trace selects reads, writes or both
// - overflow halts CPU or sends error, sync
`timescale 1ns/100ps
`default_nettype none
module ocdc_ctrl
    import ocdc_pkg::*;
#(
    parameter int DEPTH = OCDC_QDEPTH_DEF,
    parameter int SYNC_PERIOD = OCDC_SYNC_DEF
) (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    // Register port from the CPU
    input wire ocdc_req_t reg_req_in,
    output logic [31:0] reg_rdata_out,
    // CPU activity
    input wire logic fetch_valid_in,
    input wire logic [31:0] fetch_pc_in,
    input wire ocdc_dacc_t dacc_in,
    input wire ocdc_cof_t cof_in,
    input wire logic bkpt_instr_in,
    input wire logic retd_in,
    input wire logic dinst_take_in,
    // CPU control
    output logic debug_mode_out,
    output logic monitor_mode_out,
    output logic cpu_halt_out,
    output logic dinst_valid_out,
    output logic [31:0] dinst_out,
    // Serial link pins
    input wire logic link_tck_in,
    input wire logic link_tdi_in,
    input wire logic link_sel_in,
    output logic link_tdo_out,
    // Auxiliary trace port
    output logic aux_valid_out,
    output ocdc_msg_t aux_data_out,
    input wire logic aux_ready_in
);

    // ****************************************************************
    // State
    // ****************************************************************
    localparam int PW = $clog2(DEPTH);
    localparam logic [PW:0] QFULL = (PW+1)'(DEPTH);
    localparam logic [15:0] SYNC_LAST = 16'(SYNC_PERIOD - 1);

    generate
        if (DEPTH < 4 || (DEPTH & (DEPTH - 1)) != 0 || SYNC_PERIOD < 2)
        begin : g_bad
            $error("ocdc_ctrl: DEPTH power of two >= 4, SYNC_PERIOD >= 2");
        end
    endgenerate

    typedef struct packed {
        ocdc_flow_t mode;
        logic [31:0] ctrl;
        logic [31:0] bpcfg;
        logic [OCDC_NBP-1:0] hits;
        logic ovf;
        logic [31:0] dinst;
        logic full;
        logic [OCDC_NIBP-1:0][31:0] ibp;
        logic [OCDC_NDBP-1:0][31:0] dbpa;
        logic [OCDC_NDBP-1:0][31:0] dbpv;
        logic [31:0] rdata;
        logic trace_on;
        logic err;
        logic psd;
        logic dsd;
        logic [15:0] sync_cnt;
        logic [31:0] last_p;
        logic [31:0] last_d;
        ocdc_msg_t [DEPTH-1:0] q;
        logic [PW:0] wp;
        logic [PW:0] rp;
        logic [2:0] tck;
        logic [1:0] tdi;
        logic [2:0] sel;
        logic [OCDC_LINK_BITS-1:0] lsh;
        logic [5:0] lcnt;
        logic [31:0] osh;
        logic tdo;
    } ocdc_st_t;

    ocdc_st_t s_q;
    ocdc_st_t s_d;

    // ****************************************************************
    // Register access helpers
    // ****************************************************************
    // Shared by port and link so both see one register map
    function automatic ocdc_st_t wr_reg(input ocdc_st_t st,
                                        input logic [5:0] a,
                                        input logic [31:0] d);
        ocdc_st_t r;
        r = st;
        case (a)
            REG_CTRL: begin
                r.ctrl = d;
                r.ctrl[CB_HALT] = 1'b0;
                r.ctrl[CB_STEP] = 1'b0;
            end
            REG_STAT: begin
                r.hits = st.hits & ~d[SB_HIT +: OCDC_NBP];
                if (d[SB_OVF]) begin
                    r.ovf = 1'b0;
                end
            end
            REG_DINST: begin
                r.dinst = d;
                r.full = 1'b1;
            end
            REG_BPCFG: r.bpcfg = d;
            default: begin
                if (a >= REG_IBP0 && a < REG_DBPA0) begin
                    r.ibp[3'(a - REG_IBP0)] = d;
                end else if (a >= REG_DBPA0 && a < REG_DBPV0) begin
                    r.dbpa[1'(a - REG_DBPA0)] = d;
                end else if (a >= REG_DBPV0 && a < REG_DBPV0 + 6'h02) begin
                    r.dbpv[1'(a - REG_DBPV0)] = d;
                end
            end
        endcase
        return r;
    endfunction

    // Unmapped indices read as zero
    function automatic logic [31:0] rd_reg(input ocdc_st_t st,
                                           input logic [5:0] a);
        logic [31:0] v;
        v = '0;
        case (a)
            REG_CTRL: v = st.ctrl;
            REG_STAT: begin
                v[SB_DBG] = (st.mode == FL_DBG);
                v[SB_FULL] = st.full;
                v[SB_OVF] = st.ovf;
                v[SB_HIT +: OCDC_NBP] = st.hits;
            end
            REG_DINST: v = st.dinst;
            REG_BPCFG: v = st.bpcfg;
            default: begin
                if (a >= REG_IBP0 && a < REG_DBPA0) begin
                    v = st.ibp[3'(a - REG_IBP0)];
                end else if (a >= REG_DBPA0 && a < REG_DBPV0) begin
                    v = st.dbpa[1'(a - REG_DBPA0)];
                end else if (a >= REG_DBPV0 && a < REG_DBPV0 + 6'h02) begin
                    v = st.dbpv[1'(a - REG_DBPV0)];
                end
            end
        endcase
        return v;
    endfunction

    // ****************************************************************
    // Next state
    // ****************************************************************
    logic l_exec;
    logic l_wr;
    logic halt_cmd;
    logic step_cmd;
    logic [OCDC_NBP-1:0] hit;
    logic [OCDC_NBP-1:0] watch;
    logic [OCDC_NBP-1:0] brk;
    logic [PW:0] cnt;
    logic space;
    logic want_p;
    logic want_d;
    logic push;
    logic lost;
    ocdc_msg_t m;

    always_comb begin
        s_d = s_q;
        // Link pin synchronisers; stage 0 feeds stage 1 only
        s_d.tck = {s_q.tck[1:0], link_tck_in};
        s_d.sel = {s_q.sel[1:0], link_sel_in};
        s_d.tdi = {s_q.tdi[0], link_tdi_in};
        // Frame: write flag, 6-bit index, 32 data bits, LSB first
        l_exec = s_q.sel[2] && !s_q.sel[1]
                 && s_q.lcnt == 6'(OCDC_LINK_BITS);
        l_wr = l_exec && s_q.lsh[0];
        if (s_q.sel[1] && s_q.tck[1] && !s_q.tck[2]) begin
            s_d.lsh = {s_q.tdi[1], s_q.lsh[OCDC_LINK_BITS-1:1]};
            if (s_q.lcnt != 6'h3f) begin
                s_d.lcnt = s_q.lcnt + 6'h01;
            end
        end
        if (s_q.sel[1] && !s_q.tck[1] && s_q.tck[2]) begin
            s_d.tdo = s_q.osh[0];
            s_d.osh = {1'b0, s_q.osh[31:1]};
        end
        if (s_q.sel[1] != s_q.sel[2]) begin
            s_d.lcnt = '0;
        end
        // Read answer goes out in the next frame
        if (l_exec && !s_q.lsh[0]) begin
            s_d.osh = rd_reg(s_q, s_q.lsh[6:1]);
        end

        // Instruction taken empties the slot; a new write refills it
        if (dinst_take_in) begin
            s_d.full = 1'b0;
        end
        if (reg_req_in.wr) begin
            s_d = wr_reg(s_d, reg_req_in.addr, reg_req_in.wdata);
        end
        if (l_wr) begin
            s_d = wr_reg(s_d, s_q.lsh[6:1], s_q.lsh[38:7]);
        end
        s_d.rdata = reg_req_in.rd ? rd_reg(s_q, reg_req_in.addr) : '0;
        halt_cmd = (reg_req_in.wr && reg_req_in.addr == REG_CTRL
                    && reg_req_in.wdata[CB_HALT])
                   || (l_wr && s_q.lsh[6:1] == REG_CTRL
                       && s_q.lsh[7 + CB_HALT]);
        step_cmd = (reg_req_in.wr && reg_req_in.addr == REG_CTRL
                    && reg_req_in.wdata[CB_STEP])
                   || (l_wr && s_q.lsh[6:1] == REG_CTRL
                       && s_q.lsh[7 + CB_STEP]);

        // Comparators; debug code itself is never matched
        hit = '0;
        for (int i = 0; i < OCDC_NIBP; i++) begin
            hit[i] = fetch_valid_in && fetch_pc_in == s_q.ibp[i];
        end
        for (int k = 0; k < OCDC_NIBP / 2; k++) begin
            if (s_q.bpcfg[BC_RANGE + k]) begin
                hit[2*k] = fetch_valid_in && fetch_pc_in >= s_q.ibp[2*k]
                           && fetch_pc_in <= s_q.ibp[2*k+1];
                hit[2*k+1] = 1'b0;
            end
        end
        for (int j = 0; j < OCDC_NDBP; j++) begin
            hit[OCDC_NIBP+j] = dacc_in.valid
                && dacc_in.addr == s_q.dbpa[j]
                && (!s_q.bpcfg[BC_DVAL + j]
                    || dacc_in.data == s_q.dbpv[j]);
        end
        hit = hit & s_q.bpcfg[BC_EN +: OCDC_NBP]
              & {OCDC_NBP{s_q.mode != FL_DBG}};
        watch = hit & s_q.bpcfg[BC_WATCH +: OCDC_NBP];
        brk = hit & ~s_q.bpcfg[BC_WATCH +: OCDC_NBP];
        s_d.hits = s_d.hits | hit;

        // Flow control; a step command wins over a same-cycle return
        case (s_q.mode)
            FL_RUN: begin
                if (halt_cmd || bkpt_instr_in || |brk) begin
                    s_d.mode = FL_DBG;
                end
            end
            FL_DBG: begin
                if (step_cmd) begin
                    s_d.mode = FL_STEP;
                end else if (retd_in) begin
                    s_d.mode = FL_RUN;
                end
            end
            FL_STEP: begin
                if (fetch_valid_in || |brk || halt_cmd) begin
                    s_d.mode = FL_DBG;
                end
            end
            default: s_d.mode = FL_RUN;
        endcase

        // Trace triggers; stop wins over start
        if (|watch && s_q.bpcfg[BC_TSTART]) begin
            s_d.trace_on = 1'b1;
        end
        if (|watch && s_q.bpcfg[BC_TSTOP]) begin
            s_d.trace_on = 1'b0;
        end

        // Queue and message selection, one message per cycle
        cnt = s_q.wp - s_q.rp;
        space = cnt != QFULL;
        if (aux_ready_in && cnt != '0) begin
            s_d.rp = s_q.rp + 1'b1;
        end
        want_p = cof_in.valid && s_q.ctrl[CB_PTR] && s_q.trace_on;
        want_d = dacc_in.valid && s_q.ctrl[CB_DTR] && s_q.trace_on
                 && (dacc_in.write ? s_q.ctrl[CB_DWR]
                                   : s_q.ctrl[CB_DRD]);
        m = '0;
        push = 1'b0;
        lost = 1'b0;
        if (s_q.err) begin
            m.kind = MK_ERR;
            push = 1'b1;
            lost = |watch || want_p || want_d;
        end else if (|watch) begin
            m.kind = MK_WATCH;
            m.val = 32'(watch);
            push = 1'b1;
            lost = want_p || want_d;
        end else if (want_p) begin
            m.kind = s_q.psd ? MK_PSYNC : MK_PROG;
            m.val = s_q.psd ? cof_in.target
                            : cof_in.target - s_q.last_p;
            push = 1'b1;
            lost = want_d;
        end else if (want_d) begin
            m.kind = s_q.dsd ? MK_DSYNC : MK_DATA;
            m.val = s_q.dsd ? dacc_in.addr
                            : dacc_in.addr - s_q.last_d;
            push = 1'b1;
        end
        if (push && !space) begin
            push = 1'b0;
            lost = !s_q.err;
        end
        if (push) begin
            s_d.q[s_q.wp[PW-1:0]] = m;
            s_d.wp = s_q.wp + 1'b1;
            if (m.kind == MK_ERR) begin
                s_d.err = 1'b0;
                s_d.psd = 1'b1;
                s_d.dsd = 1'b1;
            end else if (m.kind != MK_WATCH) begin
                if (m.kind == MK_PROG || m.kind == MK_PSYNC) begin
                    s_d.last_p = cof_in.target;
                    s_d.psd = 1'b0;
                end else begin
                    s_d.last_d = dacc_in.addr;
                    s_d.dsd = 1'b0;
                end
                if (s_q.sync_cnt == SYNC_LAST) begin
                    s_d.sync_cnt = '0;
                    s_d.psd = 1'b1;
                    s_d.dsd = 1'b1;
                end else begin
                    s_d.sync_cnt = s_q.sync_cnt + 16'h0001;
                end
            end
        end
        // Lost message: flag it, and report unless halting instead
        if (lost) begin
            s_d.ovf = 1'b1;
            s_d.err = !s_q.ctrl[CB_OVFH];
        end
    end

    // Whole state registered at once
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            s_q <= '0;
            s_q.mode <= FL_RUN;
            s_q.ctrl <= OCDC_CTRL_RST;
            s_q.trace_on <= 1'b1;
            s_q.psd <= 1'b1;
            s_q.dsd <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    // Halt one slot early so the last event still fits
    assign cpu_halt_out = (s_q.mode == FL_DBG && !s_q.ctrl[CB_MON]
                           && !s_q.full)
                          || (s_q.ctrl[CB_OVFH]
                              && cnt >= QFULL - 1'b1);
    assign dinst_valid_out = s_q.mode == FL_DBG && !s_q.ctrl[CB_MON]
                             && s_q.full;
    assign dinst_out = s_q.dinst;
    assign debug_mode_out = s_q.mode == FL_DBG;
    assign monitor_mode_out = s_q.ctrl[CB_MON];
    assign reg_rdata_out = s_q.rdata;
    assign link_tdo_out = s_q.tdo;
    assign aux_valid_out = cnt != '0;
    assign aux_data_out = s_q.q[s_q.rp[PW-1:0]];

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (sys_rst_in);

    sequence step_fetch;
        s_q.mode == FL_STEP ##0 fetch_valid_in;
    endsequence
    sequence dinst_wr_rd;
        reg_req_in.wr && reg_req_in.addr == REG_DINST && !l_wr
        ##1 reg_req_in.rd && reg_req_in.addr == REG_DINST
            && !reg_req_in.wr && !l_wr && !dinst_take_in;
    endsequence

    chk_halt_enters: assert property (
        s_q.mode == FL_RUN && halt_cmd |=> debug_mode_out)
        else $error("halt command did not enter debug");
    chk_brk_enters: assert property (
        s_q.mode == FL_RUN && |brk |=> debug_mode_out)
        else $error("breakpoint did not enter debug");
    chk_watch_free: assert property (
        s_q.mode == FL_RUN && |watch && !(|brk) && !halt_cmd
        && !bkpt_instr_in |=> !debug_mode_out)
        else $error("watchpoint stopped the CPU");
    chk_step_single: assert property (
        step_fetch |=> debug_mode_out)
        else $error("step did not return to debug");
    chk_dinst_stall: assert property (
        debug_mode_out && !monitor_mode_out && !s_q.full
        |-> cpu_halt_out && !dinst_valid_out)
        else $error("empty instruction slot without halt");
    chk_monitor_no_dinst: assert property (
        monitor_mode_out |-> !dinst_valid_out)
        else $error("monitor mode offered debug instruction");
    chk_dinst_readback: assert property (
        dinst_wr_rd |=> reg_rdata_out == $past(reg_req_in.wdata, 2))
        else $error("instruction register readback wrong");
    chk_err_then_sync: assert property (
        push && m.kind == MK_ERR && !lost
        |=> s_q.psd && s_q.dsd && !s_q.err)
        else $error("error message not followed by sync");
    chk_loss_flagged: assert property (
        lost && !s_q.ctrl[CB_OVFH] |=> s_q.ovf && s_q.err)
        else $error("lost message not reported");
    chk_queue_count: assert property (
        push && !(aux_ready_in && cnt != '0)
        |=> cnt == $past(cnt) + 1'b1)
        else $error("queue did not take message");

endmodule // ocdc_ctrl
`default_nettype wire

// file: ocdc_pkg.sv
// Purpose: shared constants and carriers of the debug controller.
// Assumes: one register index space shared by port and link.
// Notes: register offsets are word indices on the plain port.
package ocdc_pkg;

    // ****************************************************************
    // Sizes
    // ****************************************************************
    localparam int OCDC_AW = 6;
    localparam int OCDC_NIBP = 6;
    localparam int OCDC_NDBP = 2;
    localparam int OCDC_NBP = 8;
    localparam int OCDC_LINK_BITS = 39;
    localparam int OCDC_QDEPTH_DEF = 8;
    localparam int OCDC_SYNC_DEF = 64;

    // ****************************************************************
    // Register indices
    // ****************************************************************
    localparam logic [5:0] REG_CTRL = 6'h00;
    localparam logic [5:0] REG_STAT = 6'h01;
    localparam logic [5:0] REG_DINST = 6'h02;
    localparam logic [5:0] REG_BPCFG = 6'h03;
    localparam logic [5:0] REG_IBP0 = 6'h08;
    localparam logic [5:0] REG_DBPA0 = 6'h0e;
    localparam logic [5:0] REG_DBPV0 = 6'h10;

    // ****************************************************************
    // Field positions and reset values
    // ****************************************************************
    localparam int CB_MON = 0;
    localparam int CB_HALT = 1;
    localparam int CB_STEP = 2;
    localparam int CB_OVFH = 3;
    localparam int CB_PTR = 4;
    localparam int CB_DTR = 5;
    localparam int CB_DRD = 6;
    localparam int CB_DWR = 7;
    localparam int SB_DBG = 0;
    localparam int SB_FULL = 1;
    localparam int SB_OVF = 2;
    localparam int SB_HIT = 8;
    localparam int BC_EN = 0;
    localparam int BC_WATCH = 8;
    localparam int BC_RANGE = 16;
    localparam int BC_DVAL = 19;
    localparam int BC_TSTART = 21;
    localparam int BC_TSTOP = 22;
    localparam logic [31:0] OCDC_CTRL_RST = 32'h0000_00c0;

    // ****************************************************************
    // Message kinds and types
    // ****************************************************************
    localparam logic [3:0] MK_PROG = 4'h1;
    localparam logic [3:0] MK_PSYNC = 4'h2;
    localparam logic [3:0] MK_DATA = 4'h3;
    localparam logic [3:0] MK_DSYNC = 4'h4;
    localparam logic [3:0] MK_WATCH = 4'h5;
    localparam logic [3:0] MK_ERR = 4'h6;

    typedef enum logic [1:0] {FL_RUN, FL_DBG, FL_STEP} ocdc_flow_t;
    typedef struct packed {
        logic [3:0] kind;
        logic [31:0] val;
    } ocdc_msg_t;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [5:0] addr;
        logic [31:0] wdata;
    } ocdc_req_t;
    typedef struct packed {
        logic valid;
        logic write;
        logic [31:0] addr;
        logic [31:0] data;
    } ocdc_dacc_t;
    typedef struct packed {
        logic valid;
        logic [31:0] target;
    } ocdc_cof_t;

endpackage

// file: ocdc_emu.sv
// Purpose: emulator model: sends link frames, sinks trace messages.
// Assumes: link clock runs only inside frames, 125 ns period.
// Notes: outside a frame tdi shows the inverse of the last bit.
`timescale 1ns/100ps
`default_nettype none
module ocdc_emu
    import ocdc_pkg::*;
(
    // Link pins toward the block
    output logic link_tck_out,
    output logic link_tdi_out,
    output logic link_sel_out,
    input wire logic link_tdo_in,
    // Trace sink control
    input wire logic stall_in,
    output logic aux_ready_out
);
    // ********************************
    // Trace sink
    // ********************************
    // Sink only stalls when the bench asks for it
    assign aux_ready_out = !stall_in;

    initial begin
        link_tck_out = 1'b0;
        link_tdi_out = 1'b0;
        link_sel_out = 1'b0;
    end

    // One indexed register message, LSB first; clock idle between frames
    // Reply bit k is taken at rise k+1, after the block's k-th fall
    task automatic send(input logic [38:0] frame, output logic [31:0] reply);
        int i;
        reply = '0;
        link_sel_out = 1'b1;
        #125;
        for (i = 0; i < OCDC_LINK_BITS; i++) begin
            link_tdi_out = frame[i];
            #62.5 link_tck_out = 1'b1;
            if (i > 0 && i < 33) reply[i-1] = link_tdo_in;
            #62.5 link_tck_out = 1'b0;
        end
        #62.5 link_sel_out = 1'b0;
        link_tdi_out = ~frame[38];
    endtask
endmodule // ocdc_emu
`default_nettype wire

// file: on_chip_debug_control_test.sv
// Purpose: self-checking bench of the debug controller.
// Assumes: queue depth 4, so overflow shows after three entries.
// Notes: each scenario task drives and judges on its own.
`timescale 1ns/100ps
`default_nettype none
module on_chip_debug_control_test
    import ocdc_pkg::*;
();
    localparam logic [31:0] ONE = 32'h0000_0001;
    localparam logic [31:0] ZERO = 32'h0000_0000;
    localparam logic [5:0] E_DW = 6'h20;
    localparam logic [5:0] E_FE = 6'h10;
    localparam logic [5:0] E_CF = 6'h08;
    localparam logic [5:0] E_BK = 6'h04;
    localparam logic [5:0] E_RT = 6'h02;
    localparam logic [5:0] E_TK = 6'h01;
    logic clk, rst, fv, bk, rt, tk, tck, tdi, sel, tdo, stall, ar;
    logic dbg, mon, halt, dv, av;
    logic [31:0] pc, rdata, dinst, lr;
    ocdc_req_t req;
    ocdc_dacc_t dacc;
    ocdc_cof_t cof;
    ocdc_msg_t ad;
    int n_errors, checked, cycles;

    ocdc_ctrl #(.DEPTH(4), .SYNC_PERIOD(64)) u_ocdc_ctrl (
        .ref_clk_in(clk), .sys_rst_in(rst), .reg_req_in(req),
        .reg_rdata_out(rdata), .fetch_valid_in(fv), .fetch_pc_in(pc),
        .dacc_in(dacc), .cof_in(cof), .bkpt_instr_in(bk), .retd_in(rt),
        .dinst_take_in(tk), .debug_mode_out(dbg), .monitor_mode_out(mon),
        .cpu_halt_out(halt), .dinst_valid_out(dv), .dinst_out(dinst),
        .link_tck_in(tck), .link_tdi_in(tdi), .link_sel_in(sel),
        .link_tdo_out(tdo), .aux_valid_out(av), .aux_data_out(ad),
        .aux_ready_in(ar));
    ocdc_emu u_ocdc_emu (.link_tck_out(tck), .link_tdi_out(tdi),
        .link_sel_out(sel), .link_tdo_in(tdo), .stall_in(stall),
        .aux_ready_out(ar));

    // ********************************
    // Shared helpers
    // ********************************
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic chk(input string n, input logic [31:0] s, e);
        checked++;
        if (s !== e) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        @(posedge clk);
        req <= '{1'b1, 1'b0, a, d};
        @(posedge clk);
        req <= '0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [5:0] a, input logic [31:0] e);
        @(posedge clk);
        req <= '{1'b0, 1'b1, a, ZERO};
        @(posedge clk);
        req <= '0;
        @(negedge clk);
        chk("rdata", rdata, e);
    endtask
    // Write then read the same index with no gap between strobes
    task automatic wr_rd(input logic [5:0] a, input logic [31:0] d);
        @(posedge clk);
        req <= '{1'b1, 1'b0, a, d};
        @(posedge clk);
        req <= '{1'b0, 1'b1, a, ZERO};
        @(posedge clk);
        req <= '0;
        @(negedge clk);
        chk("rdata", rdata, d);
    endtask
    // One-cycle CPU event pulses, picked by mask
    task automatic ev(input logic [5:0] m, input logic [31:0] a);
        @(posedge clk);
        {fv, bk, rt, tk} <= {m[4], m[2:0]};
        cof <= '{m[3], a};
        dacc <= '{m[5], 1'b1, a, ZERO};
        pc <= a;
        @(posedge clk);
        {fv, bk, rt, tk} <= 4'h0;
        cof <= '0;
        dacc <= '0;
    endtask
    task automatic msg(input logic [3:0] k, input logic [31:0] v);
        chk("kind", 32'(ad.kind), 32'(k));
        chk("val", ad.val, v);
    endtask

    // ********************************
    // Scenarios
    // ********************************
    task automatic t_ext();
        rd(REG_CTRL, OCDC_CTRL_RST);
        rd(6'h3f, ZERO);
        wr(REG_CTRL, 32'h0000_00c2);
        cyc(2);
        chk("debug", 32'(dbg), ONE);
        chk("halt", 32'(halt), ONE);
        wr_rd(REG_DINST, 32'h1234_5678);
        cyc(1);
        chk("dinst", dinst, 32'h1234_5678);
        chk("halt", 32'(halt), ZERO);
        rd(REG_STAT, 32'h0000_0003);
        ev(E_TK, ZERO);
        cyc(1);
        chk("dinst_valid", 32'(dv), ZERO);
        ev(E_RT, ZERO);
        cyc(1);
        chk("debug", 32'(dbg), ZERO);
        $display("test external done");
    endtask
    task automatic t_mon();
        wr(REG_CTRL, 32'h0000_00c1);
        ev(E_BK, ZERO);
        cyc(2);
        chk("debug", 32'(dbg), ONE);
        chk("halt", 32'(halt), ZERO);
        chk("monitor", 32'(mon), ONE);
        wr(REG_CTRL, 32'h0000_00c5);
        cyc(2);
        chk("debug", 32'(dbg), ZERO);
        ev(E_FE, 32'h0000_0200);
        cyc(2);
        chk("debug", 32'(dbg), ONE);
        ev(E_RT, ZERO);
        $display("test monitor done");
    endtask
    // Range pair 0,1 and the last instruction comparator
    task automatic t_bp();
        wr(REG_CTRL, OCDC_CTRL_RST);
        wr(REG_IBP0, 32'h0000_0100);
        wr(REG_IBP0 + 6'h01, 32'h0000_01ff);
        wr(REG_IBP0 + 6'h05, 32'h0000_0400);
        wr(REG_BPCFG, 32'h0001_0023);
        ev(E_FE, 32'h0000_0200);
        cyc(2);
        chk("debug", 32'(dbg), ZERO);
        ev(E_FE, 32'h0000_0180);
        cyc(2);
        chk("debug", 32'(dbg), ONE);
        ev(E_RT, ZERO);
        ev(E_FE, 32'h0000_0400);
        cyc(2);
        chk("debug", 32'(dbg), ONE);
        rd(REG_STAT, 32'h0000_2101);
        wr(REG_STAT, 32'h0000_ff00);
        ev(E_RT, ZERO);
        $display("test breakpoint done");
    endtask
    task automatic t_watch();
        wr(REG_BPCFG, 32'h0000_4040);
        wr(REG_DBPA0, 32'h0000_2000);
        ev(E_DW, 32'h0000_2000);
        cyc(2);
        chk("debug", 32'(dbg), ZERO);
        msg(MK_WATCH, 32'h0000_0040);
        @(posedge clk);
        stall <= 1'b0;
        cyc(2);
        chk("aux_valid", 32'(av), ZERO);
        stall <= 1'b1;
        wr(REG_BPCFG, ZERO);
        $display("test watch done");
    endtask
    // Overflow halt at depth minus one, first message absolute
    task automatic t_trace();
        wr(REG_CTRL, 32'h0000_00d8);
        ev(E_CF, 32'h0000_1000);
        ev(E_CF, 32'h0000_1010);
        cyc(1);
        chk("halt", 32'(halt), ZERO);
        msg(MK_PSYNC, 32'h0000_1000);
        ev(E_CF, 32'h0000_1020);
        cyc(1);
        chk("halt", 32'(halt), ONE);
        @(posedge clk);
        stall <= 1'b0;
        @(posedge clk);
        stall <= 1'b1;
        cyc(1);
        msg(MK_PROG, 32'h0000_0010);
        chk("halt", 32'(halt), ZERO);
        $display("test trace done");
    endtask
    task automatic t_link();
        u_ocdc_emu.send({32'h0000_00c1, REG_CTRL, 1'b1}, lr);
        cyc(8);
        rd(REG_CTRL, 32'h0000_00c1);
        u_ocdc_emu.send({ZERO, REG_CTRL, 1'b0}, lr);
        cyc(8);
        u_ocdc_emu.send({ZERO, REG_CTRL, 1'b0}, lr);
        chk("link_reply", lr, 32'h0000_00c1);
        $display("test link done");
    endtask

    task automatic report_and_stop();
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Hang guard well above the link frame and all scenarios
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            report_and_stop();
        end
    end
    initial begin
        {rst, stall} = 2'b11;
        {fv, bk, rt, tk} = 4'h0;
        {pc, req, dacc, cof} = '0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_ext();
        t_mon();
        t_bp();
        t_watch();
        t_trace();
        t_link();
        report_and_stop();
    end
endmodule // on_chip_debug_control_test
`default_nettype wire
